// file: led_i2c_slave.sv
// i2c slave front end: bit transfer, start/stop, acknowledge and call address matching
//
// Contract
// - group call address resets to d0h
// - group matching on at reset, acks d0h/d1h
// - sub call addresses reset to d2h, d4h, d8h
// - sub matching off at reset, no ack
// - call addresses writable, volatile, default after reset
// - sub address regular only while enable set
// - soft reset address acked only for write
// - idle bus high, start only when free
// - one bit per clock, sda stable high
// - sda fall start, sda rise stop, scl high
// - eight bits then one acknowledge clock
// - receiver pulls sda low during acknowledge
// - transmitter releases sda after master nack
// - multiplier bit selects ratio 15 or 5
// - address lsb one reads, zero writes
// - byte after address is pointer, five bits
`timescale 1ns/10ps
module led_i2c_slave (
    input  wire logic                    clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    ce_i,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    input  wire logic [6:0]              own_addr_i,
    output logic                         sda_o,
    output logic                         sda_oe_n_o,
    output led_i2c_pkg::call_addr_t      call_addr_o,
    output logic [7:0]                   first_mode_register_o,
    output logic [7:0]                   second_mode_register_o,
    output logic                         current_multiplier_bit_o,
    output logic [3:0]                   current_ratio_o,
    output led_i2c_pkg::reg_write_t      reg_write_o,
    output logic                         soft_reset_o,
    output logic                         busy_o
);
    import led_i2c_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;

    // idle bus rests high, so sync flops reset to one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else if (ce_i) begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
        end
    end

    logic scl_rise, scl_fall, start_w, stop_w;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_w  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_w   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ------------------------------------------------------------
    // address and configuration storage
    // ------------------------------------------------------------
    slave_state_t state_q;
    logic [7:0]   shift_q, tx_q, grp_q, first_mode_register_q, second_mode_register_q, cfg_q;
    logic [7:0]   sub_q [3];
    logic [4:0]   ptr_q;
    logic [2:0]   bit_q;
    logic         full_q, addr_ph_q, ptr_ph_q, rd_q, swr_q, mack_q, sda_oe_n_q;
    logic         wr_commit, soft_fire;
    logic [2:0]   sub_hit;
    logic         grp_hit, own_hit, swr_hit, addr_hit, byte_end;

    localparam logic [7:0] SUB_RST [3] = '{SUB1_ADDR_RST, SUB2_ADDR_RST, SUB3_ADDR_RST};

    assign byte_end  = (state_q == ST_RX) & scl_fall & full_q;
    assign wr_commit = byte_end & ~addr_ph_q & ~ptr_ph_q;
    assign soft_fire = (state_q == ST_ACK) & scl_fall & swr_q;

    // per sub address: storage and enable-gated match
    for (genvar k = 0; k < 3; k++) begin : g_sub
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sub_q[k] <= SUB_RST[k];
            end else if (ce_i) begin
                if (soft_fire) begin
                    sub_q[k] <= SUB_RST[k];
                end else if (wr_commit && ptr_q == IDX_SUB1 + 5'(k)) begin
                    sub_q[k] <= shift_q;
                end
            end
        end
        // sub matching only with its own enable bit, off after reset
        assign sub_hit[k] = first_mode_register_q[SUB_EN_LSB + k] & (shift_q[7:1] == sub_q[k][7:1]);
    end

    // group address, mode and current configuration registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            grp_q   <= GRP_ADDR_RST;
            first_mode_register_q <= FIRST_MODE_REGISTER_RST;
            second_mode_register_q <= SECOND_MODE_REGISTER_RST;
            cfg_q   <= CFG_RST;
        end else if (ce_i) begin
            if (soft_fire) begin
                grp_q   <= GRP_ADDR_RST;
                first_mode_register_q <= FIRST_MODE_REGISTER_RST;
                second_mode_register_q <= SECOND_MODE_REGISTER_RST;
                cfg_q   <= CFG_RST;
            end else if (wr_commit) begin
                unique case (ptr_q)
                    IDX_GRP:   grp_q   <= shift_q;
                    IDX_FIRST_MODE_REGISTER: first_mode_register_q <= shift_q;
                    IDX_SECOND_MODE_REGISTER: second_mode_register_q <= shift_q;
                    IDX_CFG:   cfg_q   <= shift_q;
                    default:   ;
                endcase
            end
        end
    end

    // address decode over the completed first byte
    assign grp_hit  = first_mode_register_q[GRP_EN_BIT] & (shift_q[7:1] == grp_q[7:1]);
    assign own_hit  = shift_q[7:1] == own_addr_i;
    assign swr_hit  = (shift_q[7:1] == SOFT_RESET_ADDR) & ~shift_q[0];
    assign addr_hit = own_hit | grp_hit | (|sub_hit) | swr_hit;

    // read data for the current pointer; unmapped indices read zero
    function automatic logic [7:0] read_mux(input logic [4:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == IDX_FIRST_MODE_REGISTER) v = first_mode_register_q;
        if (idx == IDX_SECOND_MODE_REGISTER) v = second_mode_register_q;
        if (idx == IDX_GRP)   v = grp_q;
        if (idx == IDX_CFG)   v = cfg_q;
        for (int j = 0; j < 3; j++) begin
            if (idx == IDX_SUB1 + 5'(j)) v = sub_q[j];
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    // start and stop win over any bit activity in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
            shift_q    <= 8'h00;
            tx_q       <= 8'h00;
            bit_q      <= 3'h0;
            full_q     <= 1'b0;
            addr_ph_q  <= 1'b0;
            ptr_ph_q   <= 1'b0;
            rd_q       <= 1'b0;
            swr_q      <= 1'b0;
            mack_q     <= 1'b0;
            ptr_q      <= 5'h00;
        end else if (ce_i) begin
            if (start_w) begin
                state_q    <= ST_RX;
                sda_oe_n_q <= 1'b1;
                bit_q      <= 3'h0;
                full_q     <= 1'b0;
                addr_ph_q  <= 1'b1;
                swr_q      <= 1'b0;
            end else if (stop_w) begin
                state_q    <= ST_IDLE;
                sda_oe_n_q <= 1'b1;
                addr_ph_q  <= 1'b0;
                ptr_ph_q   <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE, ST_IGNORE: sda_oe_n_q <= 1'b1;
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s_q};
                            bit_q   <= bit_q + 3'h1;
                            full_q  <= bit_q == LAST_BIT;
                        end else if (byte_end) begin
                            full_q <= 1'b0;
                            if (addr_ph_q) begin
                                addr_ph_q <= 1'b0;
                                rd_q      <= shift_q[0];
                                ptr_ph_q  <= ~shift_q[0] & ~swr_hit;
                                swr_q     <= swr_hit & ~own_hit;
                                state_q   <= addr_hit ? ST_ACK : ST_IGNORE;
                                sda_oe_n_q <= ~addr_hit;
                            end else begin
                                if (ptr_ph_q) begin
                                    ptr_q <= shift_q[PTR_W-1:0];
                                end
                                ptr_ph_q   <= 1'b0;
                                state_q    <= ST_ACK;
                                sda_oe_n_q <= 1'b0;
                            end
                        end
                    end
                    ST_ACK: begin
                        // hold sda low across the whole ack clock high phase
                        if (scl_fall) begin
                            if (swr_q) begin
                                state_q    <= ST_IGNORE;
                                sda_oe_n_q <= 1'b1;
                            end else if (rd_q) begin
                                state_q    <= ST_TX;
                                tx_q       <= read_mux(ptr_q);
                                sda_oe_n_q <= read_mux(ptr_q) >> 7 == 8'h00 ? 1'b0 : 1'b1;
                            end else begin
                                state_q    <= ST_RX;
                                sda_oe_n_q <= 1'b1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_q  <= bit_q + 3'h1;
                            full_q <= bit_q == LAST_BIT;
                        end else if (scl_fall) begin
                            if (full_q) begin
                                full_q     <= 1'b0;
                                state_q    <= ST_TXACK;
                                sda_oe_n_q <= 1'b1;
                            end else begin
                                // data changes only while scl is low
                                tx_q       <= {tx_q[6:0], 1'b0};
                                sda_oe_n_q <= tx_q[6];
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s_q;
                            if (sda_s_q) begin
                                state_q <= ST_IGNORE;
                            end
                        end else if (scl_fall && mack_q) begin
                            mack_q     <= 1'b0;
                            state_q    <= ST_TX;
                            tx_q       <= read_mux(ptr_q);
                            sda_oe_n_q <= read_mux(ptr_q) >> 7 == 8'h00 ? 1'b0 : 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_write_o              <= '0;
            soft_reset_o             <= 1'b0;
            current_multiplier_bit_o <= CFG_RST[CM_BIT];
            current_ratio_o          <= RATIO_HIGH;
            busy_o                   <= 1'b0;
        end else if (ce_i) begin
            reg_write_o              <= '{strobe: wr_commit, index: ptr_q, data: shift_q};
            soft_reset_o             <= soft_fire;
            current_multiplier_bit_o <= cfg_q[CM_BIT];
            current_ratio_o          <= cfg_q[CM_BIT] ? RATIO_HIGH : RATIO_LOW;
            busy_o                   <= state_q != ST_IDLE;
        end
    end

    assign sda_oe_n_o             = sda_oe_n_q;
    assign sda_o                  = 1'b0;
    assign call_addr_o            = '{group_addr: grp_q, sub_one: sub_q[0], sub_two: sub_q[1], sub_three: sub_q[2]};
    assign first_mode_register_o  = first_mode_register_q;
    assign second_mode_register_o = second_mode_register_q;

    // ------------------------------------------------------------
    // assertions and coverage
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_idle_release: assert property (state_q == ST_IDLE |-> sda_oe_n_o)
        else $error("sda driven while idle");
    a_start_detect: assert property (ce_i && start_w |=> state_q == ST_RX && addr_ph_q)
        else $error("start not taken");
    a_stop_detect: assert property (ce_i && stop_w && !start_w |=> state_q == ST_IDLE)
        else $error("stop not taken");
    a_ack_holds_low: assert property (state_q == ST_ACK |-> !sda_oe_n_o)
        else $error("ack not driven low");
    a_nack_release: assert property (ce_i && state_q == ST_TXACK && scl_rise && sda_s_q && !stop_w && !start_w
        |=> state_q == ST_IGNORE ##1 sda_oe_n_o)
        else $error("sda held after master nack");
    a_unmatched_quiet: assert property (ce_i && byte_end && addr_ph_q && !addr_hit && !start_w && !stop_w
        |=> state_q == ST_IGNORE && sda_oe_n_o)
        else $error("unmatched address acked");
    a_soft_read_nack: assert property (ce_i && byte_end && addr_ph_q && shift_q == {SOFT_RESET_ADDR, 1'b1}
        && !own_hit && !grp_hit && sub_hit == 3'h0 && !start_w && !stop_w |=> state_q == ST_IGNORE)
        else $error("soft reset read acked");
    a_tx_stable_high: assert property (ce_i && state_q == ST_TX && scl_s_q && scl_p_q && !start_w && !stop_w
        |=> $stable(sda_oe_n_o))
        else $error("sda moved while scl high");
    a_ratio_map: assert property (current_ratio_o == (current_multiplier_bit_o ? RATIO_HIGH : RATIO_LOW))
        else $error("ratio disagrees with multiplier");
    a_ptr_load: assert property (ce_i && byte_end && ptr_ph_q && !addr_ph_q && !start_w && !stop_w
        |=> ptr_q == $past(shift_q[4:0]) ##1 !reg_write_o.strobe)
        else $error("pointer not loaded");

    c_write_strobe: cover property (reg_write_o.strobe);
    c_read_nack: cover property (state_q == ST_TXACK ##1 state_q == ST_IGNORE);
    c_group_ack: cover property (ce_i && byte_end && addr_ph_q && grp_hit);
    c_soft_reset: cover property (soft_reset_o);
endmodule

// file: led_i2c_pkg.sv
// constants and types shared by the led driver i2c slave front end
package led_i2c_pkg;
    // power-up values of the call addresses, byte form with direction bit 0
    localparam logic [7:0] GRP_ADDR_RST   = 8'hd0;
    localparam logic [7:0] SUB1_ADDR_RST  = 8'hd2;
    localparam logic [7:0] SUB2_ADDR_RST  = 8'hd4;
    localparam logic [7:0] SUB3_ADDR_RST  = 8'hd8;
    // reserved soft reset call address, 7-bit form
    localparam logic [6:0] SOFT_RESET_ADDR = 7'h6b;
    // first mode register: group enable bit, sub enables at lsb+k
    localparam logic [7:0] FIRST_MODE_REGISTER_RST      = 8'h01;
    localparam int         GRP_EN_BIT     = 0;
    localparam int         SUB_EN_LSB     = 1;
    localparam logic [7:0] SECOND_MODE_REGISTER_RST      = 8'h00;
    // current configuration byte, multiplier in the top bit
    localparam logic [7:0] CFG_RST        = 8'hff;
    localparam int         CM_BIT         = 7;
    localparam logic [3:0] RATIO_HIGH     = 4'hf;
    localparam logic [3:0] RATIO_LOW      = 4'h5;
    // register pointer indices
    localparam int         PTR_W          = 5;
    localparam logic [4:0] IDX_FIRST_MODE_REGISTER      = 5'h00;
    localparam logic [4:0] IDX_SECOND_MODE_REGISTER      = 5'h01;
    localparam logic [4:0] IDX_SUB1       = 5'h18;
    localparam logic [4:0] IDX_GRP        = 5'h1b;
    localparam logic [4:0] IDX_CFG        = 5'h1c;
    localparam logic [2:0] LAST_BIT       = 3'h7;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_RX     = 6'h02,
        ST_ACK    = 6'h04,
        ST_TX     = 6'h08,
        ST_TXACK  = 6'h10,
        ST_IGNORE = 6'h20
    } slave_state_t;

    typedef struct packed {
        logic [7:0] group_addr;
        logic [7:0] sub_one;
        logic [7:0] sub_two;
        logic [7:0] sub_three;
    } call_addr_t;

    typedef struct packed {
        logic       strobe;
        logic [4:0] index;
        logic [7:0] data;
    } reg_write_t;
endpackage

// file: i2c_master_model.sv
// behavioural i2c bus master that drives the slave front end
`timescale 1ns/10ps
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic dev_sda_i,
    input  wire logic dev_sda_oe_n_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic scl_q = 1'b1;
    logic drv_q = 1'b1;
    // ----------------------------------------
    // wired bus
    // ----------------------------------------
    // pull-up wins unless someone pulls low, so a released line reads high
    assign sda_o = drv_q & (dev_sda_oe_n_i | dev_sda_i);
    assign scl_o = scl_q;
    // ----------------------------------------
    // bus phases, 4 clk low and 4 clk high, 400 ns per bit
    // ----------------------------------------
    // device answers 3 clk after the pin fall, one clk before scl rises again
    task automatic xfer_bit(input logic b, output logic s);
        repeat (2) @(posedge clk_i);
        drv_q <= b;
        repeat (2) @(posedge clk_i);
        scl_q <= 1'b1;
        repeat (2) @(posedge clk_i);
        s = sda_o;
        repeat (2) @(posedge clk_i);
        scl_q <= 1'b0;
    endtask
    // callers never use the group default or soft reset code as a plain address
    task automatic start();
        repeat (2) @(posedge clk_i);
        drv_q <= 1'b1;
        repeat (2) @(posedge clk_i);
        scl_q <= 1'b1;
        repeat (2) @(posedge clk_i);
        drv_q <= 1'b0;
        repeat (2) @(posedge clk_i);
        scl_q <= 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(posedge clk_i);
        drv_q <= 1'b0;
        repeat (2) @(posedge clk_i);
        scl_q <= 1'b1;
        repeat (2) @(posedge clk_i);
        drv_q <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
    // address lsb carries direction, chosen by the caller
    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], s);
        end
        xfer_bit(1'b1, nack);
    endtask
    // master acks every byte but the last one
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(nack, s);
    endtask
endmodule

// file: led_i2c_slave_tb_top.sv
// self-checking bench for the led driver i2c slave front end
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t: got %h exp %h", $time, a, e); end end
module led_i2c_slave_tb_top;
    import led_i2c_pkg::*;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             scl, sda, sda_dev, oe_n, cm, srst, busy, nk;
    logic [7:0]       first_mode_register, second_mode_register, rnd;
    logic [3:0]       ratio;
    call_addr_t       calls;
    reg_write_t       wr, wr_last;
    logic             ign_mon = 1'b0;
    int               error_cnt = 0;
    int               n_checks = 0;
    int               srst_cnt = 0;
    int               ign_hits = 0;
    logic [7:0]       sub_bytes [6] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd8, 8'hd9};
    always #25 clk = ~clk;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    led_i2c_slave dut (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
        .own_addr_i(7'h60), .sda_o(sda_dev), .sda_oe_n_o(oe_n), .call_addr_o(calls),
        .first_mode_register_o(first_mode_register), .second_mode_register_o(second_mode_register),
        .current_multiplier_bit_o(cm), .current_ratio_o(ratio), .reg_write_o(wr),
        .soft_reset_o(srst), .busy_o(busy));
    i2c_master_model mst (.clk_i(clk), .dev_sda_i(sda_dev), .dev_sda_oe_n_i(oe_n), .scl_o(scl), .sda_o(sda));
    // pulse catcher, since strobes stand one cycle only
    always @(posedge clk) begin
        if (wr.strobe === 1'b1) wr_last <= wr;
        if (srst === 1'b1) srst_cnt++;
        if (ign_mon && oe_n !== 1'b1) ign_hits++;
    end
    function automatic logic [3:0] exp_ratio(input logic [7:0] c);
        return c[CM_BIT] ? RATIO_HIGH : RATIO_LOW;
    endfunction
    // ----------------------------------------
    // transfer tasks
    // ----------------------------------------
    task automatic probe(input logic [7:0] a, input logic acked);
        logic [7:0] d;
        mst.start();
        mst.send_byte(a, nk);
        `CHK(nk, ~acked)
        `CHK(busy, 1'b1)
        if (acked && a[0]) mst.recv_byte(1'b1, d);
        mst.stop();
        repeat (6) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask
    task automatic wr_reg(input logic [4:0] idx, input logic [7:0] d);
        mst.start();
        mst.send_byte({7'h60, 1'b0}, nk);
        mst.send_byte({3'h0, idx}, nk);
        mst.send_byte(d, nk);
        `CHK(nk, 1'b0)
        mst.stop();
    endtask
    task automatic rd_reg(input logic [4:0] idx, input logic [7:0] e);
        logic [7:0] d;
        mst.start();
        mst.send_byte({7'h60, 1'b0}, nk);
        mst.send_byte({3'h0, idx}, nk);
        mst.start();
        mst.send_byte({7'h60, 1'b1}, nk);
        `CHK(nk, 1'b0)
        mst.recv_byte(1'b0, d);
        `CHK(d, e)
        mst.recv_byte(1'b1, d);
        `CHK(d, e)
        repeat (4) @(posedge clk);
        `CHK(oe_n, 1'b1)
        mst.stop();
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rnd = 8'($urandom(24));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(calls, {GRP_ADDR_RST, SUB1_ADDR_RST, SUB2_ADDR_RST, SUB3_ADDR_RST})
        `CHK(first_mode_register, FIRST_MODE_REGISTER_RST)
        `CHK(second_mode_register, SECOND_MODE_REGISTER_RST)
        `CHK({cm, ratio}, {1'b1, RATIO_HIGH})
        probe(8'hd0, 1'b1);
        probe(8'hd1, 1'b1);
        foreach (sub_bytes[i]) probe(sub_bytes[i], 1'b0);
        probe({SOFT_RESET_ADDR, 1'b1}, 1'b0);
        // foreign addresses: no ack, and the data byte after stays untouched
        for (int i = 0; i < 4; i++) begin
            do rnd = 8'($urandom);
            while (rnd[7:1] inside {7'h60, 7'h68, 7'h69, 7'h6a, 7'h6c, SOFT_RESET_ADDR});
            mst.start();
            mst.send_byte(rnd, nk);
            `CHK(nk, 1'b1)
            ign_mon = 1'b1;
            mst.send_byte(8'($urandom), nk);
            ign_mon = 1'b0;
            mst.stop();
        end
        `CHK(ign_hits, 0)
        wr_reg(IDX_FIRST_MODE_REGISTER, 8'h0e);
        `CHK(first_mode_register, 8'h0e)
        foreach (sub_bytes[i]) probe(sub_bytes[i], 1'b1);
        probe(8'hd0, 1'b0);
        rd_reg(IDX_FIRST_MODE_REGISTER, 8'h0e);
        // move sub two to a fresh address and reach the device through it
        rnd = {3'h5, 4'($urandom), 1'b0};
        wr_reg(IDX_SUB1 + 5'h1, rnd);
        `CHK(calls.sub_two, rnd)
        probe(rnd, 1'b1);
        rnd = {3'h7, 4'($urandom), 1'b0};
        wr_reg(IDX_GRP, rnd);
        `CHK(calls.group_addr, rnd)
        rnd = 8'($urandom);
        wr_reg(IDX_CFG, rnd);
        `CHK(wr_last, {1'b1, IDX_CFG, rnd})
        `CHK(ratio, exp_ratio(rnd))
        wr_reg(IDX_CFG, ~rnd);
        `CHK({cm, ratio}, {~rnd[CM_BIT], exp_ratio(~rnd)})
        // second mode register is stored only, read back through the pointer
        rnd = 8'($urandom);
        wr_reg(IDX_SECOND_MODE_REGISTER, rnd);
        `CHK(second_mode_register, rnd)
        rd_reg(IDX_SECOND_MODE_REGISTER, rnd);
        probe({SOFT_RESET_ADDR, 1'b0}, 1'b1);
        `CHK(srst_cnt, 1)
        `CHK({first_mode_register, second_mode_register, cm}, {FIRST_MODE_REGISTER_RST, SECOND_MODE_REGISTER_RST, 1'b1})
        `CHK(calls, {GRP_ADDR_RST, SUB1_ADDR_RST, SUB2_ADDR_RST, SUB3_ADDR_RST})
        report_and_stop();
    end
    // hang guard, several times the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
